// ---- verilog/wd_watchdog.sv ----
// digital watchdog downcounter with wishbone register access
module wd_watchdog
    import wd_pkg::*;
#(
    parameter bit          HW_ACTIVATION = 1'b0, // hardware activation option
    parameter bit          EXT_STOP_CTRL = 1'b0, // external stop-mode control
    parameter int unsigned STAB_CYCLES   = 2048  // stabilisation delay, clocks
) (
    input  wire logic       clk_i,             // oscillator clock
    input  wire logic       rst_i,             // synchronous reset, high
    input  wire wd_wb_req_s wb_req_i,          // wishbone request
    output wd_wb_rsp_s      wb_rsp_o,          // wishbone answer
    input  wire logic       nmi_pin_i,         // nmi pin level, async
    input  wire logic       stop_instr_i,      // core executes stop, pulse
    input  wire logic       wait_instr_i,      // core executes wait, pulse
    input  wire logic       wake_req_i,        // interrupt pending, level
    input  wire logic       global_irq_enable_i, // interrupt enable bit
    output logic            sys_reset_o,       // internal system reset
    output logic            reset_pin_o,       // reset pin drive value
    output logic            reset_pin_oe_o,    // reset pin drive enable
    output logic            cpu_wait_o,        // core held in wait
    output logic            osc_stop_o         // oscillator stopped
);

    // stretch counter runs from HOLD_LAST down to zero
    localparam logic [15:0] HOLD_LAST = 16'(STAB_CYCLES - 1);

    // byte address match; only lane 0 carries the register
    function automatic logic addr_hit(input logic [7:0] adr,
                                      input logic [7:0] offset);
        return adr == offset;
    endfunction : addr_hit

    // nmi pin synchroniser
    logic       nmi_meta_reg;
    logic       nmi_meta_next;
    logic       nmi_sync_reg;
    logic       nmi_sync_next;

    // watchdog state
    logic       arm_reg;
    logic       arm_next;
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    wd_pmode_e  pm_reg;
    wd_pmode_e  pm_next;
    logic       hold_reg;
    logic       hold_next;
    logic [15:0] hold_cnt_reg;
    logic [15:0] hold_cnt_next;
    logic       cause_reg;
    logic       cause_next;
    logic       restart_pre;

    // bus state
    logic       ack_reg;
    logic       ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;

    // derived terms
    logic       armed;
    logic       tick;
    logic       frozen;
    logic       bus_fire;
    logic       ctrl_wr;
    logic [6:0] cnt_dec;
    logic       expire;
    logic       sr_cleared;
    logic       trigger;
    logic [7:0] ctrl_view;
    logic [7:0] status_view;
    logic       ctrl_hit;
    logic       status_hit;

    // registered outputs
    logic       cpu_wait_next;
    logic       osc_stop_next;
    logic       sys_reset_next;
    logic       reset_pin_next;
    logic       reset_pin_oe_next;

    // two flops before any logic sees the pin, against metastability
    always_comb begin
        nmi_meta_next = nmi_pin_i;
        nmi_sync_next = nmi_meta_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_meta_reg <= 1'b0;
            nmi_sync_reg <= 1'b0;
        end else begin
            nmi_meta_reg <= nmi_meta_next;
            nmi_sync_reg <= nmi_sync_next;
        end
    end

    // hardware option ties the arm bit high
    assign armed   = HW_ACTIVATION ? 1'b1 : arm_reg;
    // the oscillator stops in stop mode, so the count holds its value
    assign frozen  = (pm_reg == PM_STOP) || hold_reg;
    assign cnt_dec = cnt_reg - CNT_ONE;

    // arming restarts the prescaler so a full step passes first
    assign restart_pre = hold_reg || (ctrl_wr && !armed &&
                         wb_req_i.dat[ARM_BIT]);

    wd_prescaler u_prescaler (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .run_i     (!frozen),
        .restart_i (restart_pre),
        .tick_o    (tick)
    );

    // a new request is taken only while ack is low
    assign bus_fire   = wb_req_i.cyc && wb_req_i.stb && !ack_reg;
    assign ctrl_hit   = addr_hit(wb_req_i.adr, WD_CTRL_OFFSET);
    assign status_hit = addr_hit(wb_req_i.adr, WD_STATUS_OFFSET);
    // writes while the stretch holds are dropped
    assign ctrl_wr    = bus_fire && wb_req_i.we && wb_req_i.sel[0] &&
                        ctrl_hit && !hold_reg;

    // expiry is the self-reset bit falling on a count step
    assign expire     = armed && tick && !ctrl_wr && cnt_reg[CNT_MSB] &&
                        !cnt_dec[CNT_MSB];
    // a cleared self-reset bit acts even while disarmed
    assign sr_cleared = ctrl_wr && !wb_req_i.dat[SR_BIT];
    assign trigger    = expire || sr_cleared;

    assign ctrl_view   = reg_from_count(cnt_reg, armed);

    // status is read only; writes to it are acked and dropped
    always_comb begin
        status_view              = 8'h00;
        status_view[ST_ARMED]    = armed;
        status_view[ST_WAIT]     = (pm_reg == PM_WAIT);
        status_view[ST_STOP]     = (pm_reg == PM_STOP);
        status_view[ST_FROZEN]   = frozen;
        status_view[ST_WD_CAUSE] = cause_reg;
        status_view[ST_NMI_LEVEL] = nmi_sync_reg;
    end

    // counter, arm bit and reset stretch
    always_comb begin
        arm_next      = arm_reg;
        cnt_next      = cnt_reg;
        hold_next     = hold_reg;
        hold_cnt_next = hold_cnt_reg;
        cause_next    = cause_reg;
        if (hold_reg) begin
            // restart path as for the pin, delay before release
            arm_next = WD_CTRL_RESET[ARM_BIT];
            cnt_next = count_from_reg(WD_CTRL_RESET);
            if (hold_cnt_reg == HOLD_ZERO) begin
                hold_next = 1'b0;
            end else begin
                hold_cnt_next = hold_cnt_reg - HOLD_ONE;
            end
        end else if (trigger) begin
            hold_next     = 1'b1;
            hold_cnt_next = HOLD_LAST;
            cause_next    = 1'b1;
            arm_next      = WD_CTRL_RESET[ARM_BIT];
            cnt_next      = count_from_reg(WD_CTRL_RESET);
        end else if (ctrl_wr) begin
            // reload wins over a step in the same cycle
            cnt_next = count_from_reg(wb_req_i.dat[7:0]);
            arm_next = arm_reg | wb_req_i.dat[ARM_BIT];
        end else if (tick) begin
            // disarmed the count wraps freely as a 7-bit timer
            cnt_next = cnt_dec;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arm_reg      <= WD_CTRL_RESET[ARM_BIT];
            cnt_reg      <= count_from_reg(WD_CTRL_RESET);
            hold_reg     <= 1'b0;
            hold_cnt_reg <= HOLD_ZERO;
            cause_reg    <= 1'b0;
        end else begin
            arm_reg      <= arm_next;
            cnt_reg      <= cnt_next;
            hold_reg     <= hold_next;
            hold_cnt_reg <= hold_cnt_next;
            cause_reg    <= cause_next;
        end
    end

    // power mode of the core
    always_comb begin
        pm_next = pm_reg;
        case (pm_reg)
            PM_RUN: begin
                if (stop_instr_i) begin
                    if (!armed) begin
                        pm_next = PM_STOP;
                    end else if (!EXT_STOP_CTRL) begin
                        pm_next = PM_WAIT;
                    end else if (!nmi_sync_reg) begin
                        pm_next = PM_WAIT;
                    end else begin
                        pm_next = PM_STOP;
                    end
                end else if (wait_instr_i) begin
                    pm_next = PM_WAIT;
                end
            end
            PM_WAIT, PM_STOP: begin
                // pending nmi is still serviced elsewhere, but no wake
                if (wake_req_i && global_irq_enable_i) begin
                    pm_next = PM_RUN;
                end
            end
            default: begin
                pm_next = PM_RUN;
            end
        endcase
        if (hold_reg || trigger) begin
            pm_next = PM_RUN;
        end
    end

    // open-drain: the value stays low, the enable does the driving
    always_comb begin
        cpu_wait_next     = (pm_next == PM_WAIT);
        osc_stop_next     = (pm_next == PM_STOP);
        sys_reset_next    = hold_next;
        reset_pin_next    = 1'b0;
        reset_pin_oe_next = hold_next;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pm_reg         <= PM_RUN;
            cpu_wait_o     <= 1'b0;
            osc_stop_o     <= 1'b0;
            sys_reset_o    <= 1'b0;
            reset_pin_o    <= 1'b0;
            reset_pin_oe_o <= 1'b0;
        end else begin
            pm_reg         <= pm_next;
            cpu_wait_o     <= cpu_wait_next;
            osc_stop_o     <= osc_stop_next;
            sys_reset_o    <= sys_reset_next;
            reset_pin_o    <= reset_pin_next;
            reset_pin_oe_o <= reset_pin_oe_next;
        end
    end

    // wishbone slave: one wait state, unmapped reads as zero
    always_comb begin
        ack_next  = bus_fire;
        rdat_next = BUS_ZERO;
        if (bus_fire && !wb_req_i.we) begin
            if (ctrl_hit) begin
                rdat_next[7:0] = ctrl_view;
            end else if (status_hit) begin
                rdat_next[7:0] = status_view;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= BUS_ZERO;
        end else begin
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_rsp_o.ack = ack_reg;
    assign wb_rsp_o.dat = rdat_reg;

endmodule : wd_watchdog

// ---- verilog/wd_pkg.sv ----
// constants, field layout and carrier types for the digital watchdog
package wd_pkg;

    // register map, byte addresses on the bus
    localparam logic [7:0]  WD_CTRL_OFFSET   = 8'hd8;
    localparam logic [7:0]  WD_STATUS_OFFSET = 8'hdc;

    // control register reset value and field positions
    localparam logic [7:0]  WD_CTRL_RESET    = 8'hfe;
    localparam int          ARM_BIT          = 0;
    localparam int          SR_BIT           = 1;
    localparam int          PERIOD_HI_POS    = 2;
    localparam int          PERIOD_LO_POS    = 7;
    localparam int          PERIOD_BITS      = 6;

    // status register field positions
    localparam int          ST_ARMED         = 0;
    localparam int          ST_WAIT          = 1;
    localparam int          ST_STOP          = 2;
    localparam int          ST_FROZEN        = 3;
    localparam int          ST_WD_CAUSE      = 4;
    localparam int          ST_NMI_LEVEL     = 5;

    // physical counter, bit 6 is the self-reset bit
    localparam int          CNT_W            = 7;
    localparam int          CNT_MSB          = 6;
    localparam logic [6:0]  CNT_ONE          = 7'h01;

    // prescaler: divide by 12 then by 256, one step per 3072 clocks
    localparam logic [3:0]  PRE_A_LAST       = 4'hb;
    localparam logic [7:0]  PRE_B_LAST       = 8'hff;
    localparam logic [3:0]  PRE_A_ZERO       = 4'h0;
    localparam logic [7:0]  PRE_B_ZERO       = 8'h00;
    localparam logic [3:0]  PRE_A_ONE        = 4'h1;
    localparam logic [7:0]  PRE_B_ONE        = 8'h01;

    // reset stretch counter
    localparam int          HOLD_W           = 16;
    localparam logic [15:0] HOLD_ZERO        = 16'h0000;
    localparam logic [15:0] HOLD_ONE         = 16'h0001;

    localparam logic [31:0] BUS_ZERO         = 32'h00000000;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_WAIT,
        PM_STOP
    } wd_pmode_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wd_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wd_wb_rsp_s;

    // register bits 7..2 hold counter bits 0..5 reversed, bit 1 is bit 6
    function automatic logic [6:0] count_from_reg(input logic [7:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 0; i < PERIOD_BITS; i++) begin
            c[i] = d[PERIOD_LO_POS - i];
        end
        c[CNT_MSB] = d[SR_BIT];
        return c;
    endfunction : count_from_reg

    function automatic logic [7:0] reg_from_count(input logic [6:0] c,
                                                  input logic       arm);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < PERIOD_BITS; i++) begin
            d[PERIOD_LO_POS - i] = c[i];
        end
        d[SR_BIT]  = c[CNT_MSB];
        d[ARM_BIT] = arm;
        return d;
    endfunction : reg_from_count

endpackage : wd_pkg

// ---- verilog/wd_prescaler.sv ----
// fixed two-stage prescaler giving one counter step per 3072 clocks
module wd_prescaler
    import wd_pkg::*;
(
    input  wire logic clk_i,     // oscillator clock
    input  wire logic rst_i,     // synchronous reset, active high
    input  wire logic run_i,     // oscillator running, prescaler advances
    input  wire logic restart_i, // start a fresh full step
    output logic      tick_o     // one-cycle step pulse
);

    logic [3:0] div_a_reg;
    logic [3:0] div_a_next;
    logic [7:0] div_b_reg;
    logic [7:0] div_b_next;
    logic       tick_next;

    always_comb begin
        div_a_next = div_a_reg;
        div_b_next = div_b_reg;
        tick_next  = 1'b0;
        if (restart_i) begin
            div_a_next = PRE_A_ZERO;
            div_b_next = PRE_B_ZERO;
        end else if (run_i) begin
            if (div_a_reg == PRE_A_LAST) begin
                div_a_next = PRE_A_ZERO;
                if (div_b_reg == PRE_B_LAST) begin
                    div_b_next = PRE_B_ZERO;
                    tick_next  = 1'b1;
                end else begin
                    div_b_next = div_b_reg + PRE_B_ONE;
                end
            end else begin
                div_a_next = div_a_reg + PRE_A_ONE;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_a_reg <= PRE_A_ZERO;
            div_b_reg <= PRE_B_ZERO;
            tick_o    <= 1'b0;
        end else begin
            div_a_reg <= div_a_next;
            div_b_reg <= div_b_next;
            tick_o    <= tick_next;
        end
    end

endmodule : wd_prescaler

// ---- tb/wd_watchdog_sva.sv ----
// port checker for the digital watchdog
module wd_chk
    import wd_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = 2048 // stretch length
) (
    input wire logic       clk_i,               // clock
    input wire logic       rst_i,               // reset
    input wire wd_wb_req_s wb_req_i,            // bus request
    input wire wd_wb_rsp_s wb_rsp_o,            // bus answer
    input wire logic       stop_instr_i,        // stop pulse
    input wire logic       wake_req_i,          // wake level
    input wire logic       global_irq_enable_i, // irq enable
    input wire logic       sys_reset_o,         // system reset
    input wire logic       reset_pin_o,         // pin value
    input wire logic       reset_pin_oe_o,      // pin enable
    input wire logic       cpu_wait_o,          // wait mode
    input wire logic       osc_stop_o           // stop mode
);
    int unsigned hi_next;
    int unsigned hi_reg;
    // length of the current reset stretch
    always_comb hi_next = sys_reset_o ? hi_reg + 1 : 0;
    always_ff @(posedge clk_i) hi_reg <= rst_i ? 0 : hi_next;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
    endsequence
    sequence s_sr_clear;
        s_take ##0 (wb_req_i.we && wb_req_i.adr == WD_CTRL_OFFSET
            && wb_req_i.sel[0] && !wb_req_i.dat[SR_BIT] && !sys_reset_o);
    endsequence
    a_ack_one_wait: assert property (s_take |=> wb_rsp_o.ack)
        else $error("bus answer missing");
    a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == BUS_ZERO)
        else $error("read data outside ack");
    a_sr_reset: assert property (s_sr_clear |-> ##[1:3] sys_reset_o)
        else $error("self reset write without reset");
    a_stretch_len: assert property ($fell(sys_reset_o) |->
        hi_reg == STAB_CYCLES) else $error("reset stretch length");
    a_pin_drive: assert property (reset_pin_oe_o == sys_reset_o
        && !reset_pin_o) else $error("reset pin drive");
    a_stop_entry: assert property (stop_instr_i && !osc_stop_o
        && !cpu_wait_o && !sys_reset_o |=> osc_stop_o || cpu_wait_o)
        else $error("stop instruction ignored");
    a_masked_wake: assert property (osc_stop_o && !global_irq_enable_i
        && !sys_reset_o |=> osc_stop_o) else $error("masked wake");
    a_wake_resume: assert property ((osc_stop_o || cpu_wait_o)
        && wake_req_i && global_irq_enable_i |=> !osc_stop_o && !cpu_wait_o)
        else $error("no wake");
endmodule : wd_chk

bind wd_watchdog wd_chk #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.clk_i, .rst_i,
    .wb_req_i, .wb_rsp_o, .stop_instr_i, .wake_req_i, .global_irq_enable_i,
    .sys_reset_o, .reset_pin_o, .reset_pin_oe_o, .cpu_wait_o, .osc_stop_o);

// ---- tb/wd_core_model.sv ----
// core and nmi pin model around the watchdog
module wd_core_model (
    input  wire logic clk_i,  // clock
    output logic      nmi_o,  // nmi pin level
    output logic      stop_o, // stop instruction pulse
    output logic      wait_o, // wait instruction pulse
    output logic      wake_o, // interrupt pending
    output logic      gen_o   // global irq enable
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        nmi_o = 1'h1; // idle high so stop mode stays reachable
        stop_o = 1'h0;
        wait_o = 1'h0;
        wake_o = 1'h0;
        gen_o = 1'h0;
    end
    // entered just after a rising edge, returns at the sampling edge
    task automatic instr(input logic is_stop);
        stop_o <= is_stop;
        wait_o <= !is_stop;
        @(posedge clk_i);
        stop_o <= 1'h0;
        wait_o <= 1'h0;
    endtask : instr
    task automatic levels(input logic nmi, input logic wake, input logic gen);
        nmi_o <= nmi; // low only while protection is needed
        wake_o <= wake;
        gen_o <= gen;
        @(posedge clk_i);
    endtask : levels
endmodule : wd_core_model

// ---- tb/wd_watchdog_bench.sv ----
// self-checking bench for the digital watchdog
module wd_watchdog_bench
    import wd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] adr;
        logic [3:0] sel;
        logic [7:0] wd;
        logic [7:0] exp;
    } wd_row_s;
    localparam wd_row_s ROWS [4] = '{'{8'hd8, 4'h1, 8'h7e, 8'h7e},
        '{8'hd8, 4'h0, 8'h46, 8'h7e}, '{8'hdc, 4'h1, 8'hff, 8'h20},
        '{8'h40, 4'h1, 8'haa, 8'h00}};
    logic       clk_i = 1'h0;
    logic       rst_i = 1'h1;
    wd_wb_req_s req   = '0;
    wd_wb_rsp_s rsp;
    logic       nmi, stp, wt, wake, gen, sys, pin, pin_oe, cw, os;
    logic [7:0] rd, v;
    int         num_errors = 0;
    int         tests_run = 0;
    int         now_cyc = 0;
    int         t0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) now_cyc <= now_cyc + 1;
    wd_watchdog #(.EXT_STOP_CTRL(1'h1),
        .STAB_CYCLES(4)) dut (.clk_i, .rst_i, .wb_req_i(req), .wb_rsp_o(rsp),
        .nmi_pin_i(nmi), .stop_instr_i(stp), .wait_instr_i(wt),
        .wake_req_i(wake), .global_irq_enable_i(gen), .sys_reset_o(sys),
        .reset_pin_o(pin), .reset_pin_oe_o(pin_oe), .cpu_wait_o(cw),
        .osc_stop_o(os));
    wd_core_model core (.clk_i, .nmi_o(nmi), .stop_o(stp), .wait_o(wt),
        .wake_o(wake), .gen_o(gen));
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic give_up(input string what);
        num_errors++;
        $display("unexpected %s: expected answer, seen none", what);
        end_of_test();
    endtask : give_up
    // entered just after a rising edge; ack and data taken at a rising edge
    task automatic xfer(input logic we, input logic [7:0] adr,
                        input logic [3:0] sel, input logic [7:0] wd);
        int n;
        n = 0;
        req <= '{1'h1, 1'h1, we, adr, sel, {24'h000000, wd}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'h1 && n < 50);
        if (n >= 50) give_up("bus ack");
        rd = rsp.dat[7:0];
        req <= '0;
        @(posedge clk_i);
    endtask : xfer
    // waits for the next counter step seen through the register
    task automatic poll(input logic [7:0] old);
        int n;
        n = 0;
        do begin
            xfer(1'h0, WD_CTRL_OFFSET, 4'h1, 8'h00);
            n++;
        end while (rd === old && n < 2000);
        if (n >= 2000) give_up("count step");
    endtask : poll
    // ends at a falling edge, caller realigns
    task automatic wait_sys(input logic lvl, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (sys !== lvl && n < lim);
        if (n >= lim) give_up("system reset level");
    endtask : wait_sys
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        xfer(1'h0, WD_CTRL_OFFSET, 4'h1, 8'h00);
        check("ctrl after reset", WD_CTRL_RESET, rd);
        foreach (ROWS[i]) begin
            xfer(1'h1, ROWS[i].adr, ROWS[i].sel, ROWS[i].wd);
            xfer(1'h0, ROWS[i].adr, 4'h1, 8'h00);
            check("register row", ROWS[i].exp, rd);
        end
        $display("register table done");
        xfer(1'h1, WD_CTRL_OFFSET, 4'h1, 8'h82);
        poll(8'h82);
        check("first step", 8'h02, rd);
        t0 = now_cyc;
        poll(8'h02);
        check("wrap below msb", 8'hfc, rd);
        check("step spacing", 1, now_cyc - t0 inside {[3068:3076]});
        repeat (4) @(negedge clk_i);
        check("no reset when disarmed", 0, sys);
        @(posedge clk_i);
        $display("free timer done");
        // arming restarts the prescaler, so expiry timing is exact
        xfer(1'h1, WD_CTRL_OFFSET, 4'h1, 8'h83);
        t0 = now_cyc;
        xfer(1'h0, WD_CTRL_OFFSET, 4'h1, 8'h00);
        check("armed ctrl", 8'h83, rd);
        xfer(1'h1, WD_CTRL_OFFSET, 4'h1, 8'h82);
        xfer(1'h0, WD_CTRL_OFFSET, 4'h1, 8'h00);
        check("disarm ignored", 8'h83, rd);
        wait_sys(1'h1, 7000);
        check("expiry time", 1, now_cyc - t0 inside {[6136:6156]});
        check("pin driven", 1, pin_oe);
        wait_sys(1'h0, 20);
        @(posedge clk_i);
        xfer(1'h0, WD_CTRL_OFFSET, 4'h1, 8'h00);
        check("ctrl after expiry", WD_CTRL_RESET, rd);
        xfer(1'h1, WD_CTRL_OFFSET, 4'h1, 8'h00);
        wait_sys(1'h1, 5);
        check("self reset drive", 0, pin);
        wait_sys(1'h0, 20);
        @(posedge clk_i);
        $display("reset cases done");
        core.instr(1'h1);
        @(negedge clk_i);
        check("stop when disarmed", 1, os);
        @(posedge clk_i);
        core.levels(1'h1, 1'h1, 1'h0);
        repeat (3) @(negedge clk_i);
        check("masked wake", 1, os);
        @(posedge clk_i);
        core.levels(1'h1, 1'h1, 1'h1);
        @(negedge clk_i);
        check("wake from stop", 0, os);
        @(posedge clk_i);
        core.levels(1'h1, 1'h1, 1'h0);
        core.instr(1'h0);
        repeat (3) @(negedge clk_i);
        check("masked wake from wait", 1, cw);
        @(posedge clk_i);
        core.levels(1'h1, 1'h1, 1'h1);
        @(negedge clk_i);
        check("wake from wait", 0, cw);
        @(posedge clk_i);
        core.levels(1'h0, 1'h0, 1'h1);
        repeat (3) @(posedge clk_i);
        xfer(1'h1, WD_CTRL_OFFSET, 4'h1, 8'h83);
        core.instr(1'h1);
        @(negedge clk_i);
        check("stop as wait", 1, cw);
        @(posedge clk_i);
        core.levels(1'h0, 1'h1, 1'h1);
        core.levels(1'h1, 1'h0, 1'h1);
        repeat (3) @(posedge clk_i);
        core.instr(1'h1);
        @(negedge clk_i);
        check("stop on nmi high", 1, os);
        @(posedge clk_i);
        xfer(1'h0, WD_CTRL_OFFSET, 4'h1, 8'h00);
        v = rd;
        repeat (4000) @(posedge clk_i);
        xfer(1'h0, WD_CTRL_OFFSET, 4'h1, 8'h00);
        check("frozen count", v, rd);
        core.levels(1'h1, 1'h1, 1'h1);
        core.levels(1'h1, 1'h0, 1'h1);
        wait_sys(1'h1, 7000);
        check("count resumed", 1, sys);
        $display("power modes done");
        end_of_test();
    end
endmodule : wd_watchdog_bench
